/* hdl/rpms_pkg.sv */
// package for the radio power mode sequencer
// assumes a 200 MHz system clock and a sampled spi configuration port
package rpms_pkg;

  // ----------------------------------------------------------------
  // operating mode codes, held in bits 7..5 of the mode register
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SLEEP   = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH   = 3'h2;
  localparam logic [2:0] MODE_RX      = 3'h3;
  localparam logic [2:0] MODE_TX      = 3'h4;
  localparam int         MODE_LSB     = 5;
  localparam int         MODE_MSB     = 7;

  // ----------------------------------------------------------------
  // configuration port map
  // ----------------------------------------------------------------
  localparam logic [6:0] MAIN_MODE_ADDR = 7'h00;
  localparam logic [7:0] MAIN_MODE_RST  = 8'h00;
  localparam int         FRAME_BITS     = 16;
  localparam int         ADDR_BITS      = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int XTAL_MAX_US   = 5000;
  localparam int PLL_MAX_US    = 500;
  // longest times round down; pll lock is strictly under its limit
  localparam int CYC_PER_US     = 1000000 / CLK_PERIOD_PS;
  localparam int XTAL_START_CYC = XTAL_MAX_US * CYC_PER_US;
  localparam int PLL_LOCK_CYC   = PLL_MAX_US * CYC_PER_US - 1;

  typedef struct packed
  {
    logic       read;
    logic [6:0] addr;
    logic [7:0] data;
  } rpms_frame_s;

  typedef enum
  {
    ST_SLEEP,
    ST_XTAL_START,
    ST_STANDBY,
    ST_PLL_START,
    ST_SYNTH,
    ST_RX,
    ST_TX
  } rpms_state_e;

endpackage

/* hdl/rpms_spi_port.sv */
// spi configuration port receiver, mode 0, msb first
// assumes raw pins from the host; each passes two flip-flops first
`timescale 1ns/1ps
module rpms_spi_port
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 config_port_select_n,
  input  wire logic                 spi_sck,
  input  wire logic                 spi_sdi,
  input  wire logic [7:0]           rd_data,
  output      logic                 spi_sdo,
  output      logic                 spi_sdo_oe,
  output      logic                 frame_valid,
  output rpms_pkg::rpms_frame_s     frame
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_reg <= 3'h1;
      sync_reg <= 3'h1;
      prev_reg <= 3'h1;
    end
    else
    begin
      meta_reg <= {spi_sdi, spi_sck, config_port_select_n};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic sel_start;
  logic sel_end;

  assign sel       = ~sync_reg[0];
  assign sck_rise  = sync_reg[1] & ~prev_reg[1];
  assign sck_fall  = ~sync_reg[1] & prev_reg[1];
  assign sel_start = ~sync_reg[0] & prev_reg[0];
  assign sel_end   = sync_reg[0] & ~prev_reg[0];

  // ----------------------------------------------------------------
  // shift in, count bits
  // ----------------------------------------------------------------
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic [7:0]  out_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end
    else if (sel_start)
      count_reg <= 5'h00;
    else if (sel && sck_rise)
    begin
      shift_reg <= {shift_reg[14:0], sync_reg[2]};
      if (count_reg != 5'h1F)
        count_reg <= count_reg + 5'h01;
    end
  end

  // read data loads after the address byte, shifts on falling sck
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      out_reg <= 8'h00;
    else if (sel && sck_rise && count_reg == 5'(rpms_pkg::ADDR_BITS - 1))
    begin
      // last address bit is still on the data pin at this edge
      if ({shift_reg[5:0], sync_reg[2]} == rpms_pkg::MAIN_MODE_ADDR)
        out_reg <= rd_data;
      else
        out_reg <= 8'h00;
    end
    else if (sel && sck_fall && count_reg > 5'(rpms_pkg::ADDR_BITS))
      out_reg <= {out_reg[6:0], 1'b0};
  end

  // first bit of the frame sits count_reg - 1 places up
  logic [3:0] rw_pos;

  assign rw_pos     = 4'(count_reg - 5'h01);
  assign spi_sdo    = out_reg[7];
  assign spi_sdo_oe = sel && shift_reg[rw_pos]
                      && count_reg >= 5'(rpms_pkg::ADDR_BITS)
                      && count_reg <= 5'(rpms_pkg::FRAME_BITS);

  // ----------------------------------------------------------------
  // frame completes only when select rises after exactly 16 bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      frame_valid <= 1'b0;
      frame       <= '0;
    end
    else
    begin
      frame_valid <= sel_end &&
                     count_reg == 5'(rpms_pkg::FRAME_BITS);
      if (sel_end)
        frame <= shift_reg;
    end
  end

endmodule

/* hdl/rpms_sequencer.sv */
// operating mode sequencer: oscillator, pll and radio path enables
// assumes the host keeps its side of the mode sequence and pin parking
`timescale 1ns/1ps

module rpms_sequencer
#(
  parameter int XTAL_START_CYC = rpms_pkg::XTAL_START_CYC,
  parameter int PLL_LOCK_CYC   = rpms_pkg::PLL_LOCK_CYC
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       config_port_select_n,
  input  wire logic       spi_sck,
  input  wire logic       spi_sdi,
  output      logic       spi_sdo,
  output      logic       spi_sdo_oe,
  output      logic       xtal_enable,
  output      logic       pll_enable,
  output      logic       rx_enable,
  output      logic       tx_enable,
  output      logic       clk_out_enable,
  output      logic       pll_lock,
  output      logic [2:0] op_mode
);

  localparam int CW = $clog2(XTAL_START_CYC + 1);

  // ----------------------------------------------------------------
  // configuration port
  // ----------------------------------------------------------------
  logic                  frame_valid;
  rpms_pkg::rpms_frame_s frame;
  logic [7:0]            main_mode_config_reg;

  rpms_spi_port u_spi
  (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .config_port_select_n (config_port_select_n),
    .spi_sck              (spi_sck),
    .spi_sdi              (spi_sdi),
    .rd_data              (main_mode_config_reg),
    .spi_sdo              (spi_sdo),
    .spi_sdo_oe           (spi_sdo_oe),
    .frame_valid          (frame_valid),
    .frame                (frame)
  );

  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = m <= rpms_pkg::MODE_TX;
  endfunction

  // ----------------------------------------------------------------
  // mode register; undefined mode codes leave it unchanged
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      main_mode_config_reg <= rpms_pkg::MAIN_MODE_RST;
    else if (frame_valid && !frame.read &&
             frame.addr == rpms_pkg::MAIN_MODE_ADDR &&
             mode_legal(frame.data[rpms_pkg::MODE_MSB:rpms_pkg::MODE_LSB]))
      main_mode_config_reg <= frame.data;
  end

  logic [2:0] target;
  assign target = main_mode_config_reg[rpms_pkg::MODE_MSB:rpms_pkg::MODE_LSB];

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  rpms_pkg::rpms_state_e state_reg;
  rpms_pkg::rpms_state_e state_next;
  logic [CW-1:0]         timer_reg;
  logic                  xtal_done;
  logic                  pll_done;

  assign xtal_done = timer_reg == CW'(XTAL_START_CYC - 1);
  assign pll_done  = timer_reg == CW'(PLL_LOCK_CYC - 1);

  always_comb
  begin
    state_next = state_reg;
    if (target == rpms_pkg::MODE_SLEEP)
      state_next = rpms_pkg::ST_SLEEP;
    else
    begin
      case (state_reg)
        rpms_pkg::ST_SLEEP:
          state_next = rpms_pkg::ST_XTAL_START;
        rpms_pkg::ST_XTAL_START:
          if (xtal_done)
            state_next = rpms_pkg::ST_STANDBY;
        rpms_pkg::ST_STANDBY:
          if (target != rpms_pkg::MODE_STANDBY)
            state_next = rpms_pkg::ST_PLL_START;
        rpms_pkg::ST_PLL_START:
          if (target == rpms_pkg::MODE_STANDBY)
            state_next = rpms_pkg::ST_STANDBY;
          else if (pll_done)
            state_next = rpms_pkg::ST_SYNTH;
        rpms_pkg::ST_SYNTH, rpms_pkg::ST_RX, rpms_pkg::ST_TX:
          // radio paths open only once locked
          case (target)
            rpms_pkg::MODE_STANDBY: state_next = rpms_pkg::ST_STANDBY;
            rpms_pkg::MODE_RX:      state_next = rpms_pkg::ST_RX;
            rpms_pkg::MODE_TX:      state_next = rpms_pkg::ST_TX;
            default:                state_next = rpms_pkg::ST_SYNTH;
          endcase
        default:
          state_next = rpms_pkg::ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= rpms_pkg::ST_SLEEP;
    else
      state_reg <= state_next;
  end

  // settle timer restarts on every state change
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      timer_reg <= '0;
    else if (state_next != state_reg)
      timer_reg <= '0;
    else if (state_reg == rpms_pkg::ST_XTAL_START ||
             state_reg == rpms_pkg::ST_PLL_START)
      timer_reg <= timer_reg + CW'(1);
  end

  // ----------------------------------------------------------------
  // oscillator enables, registered from the next state
  // ----------------------------------------------------------------
  // states in which the pll has reached lock
  function automatic logic state_locked(input rpms_pkg::rpms_state_e s);
    state_locked = s inside {rpms_pkg::ST_SYNTH, rpms_pkg::ST_RX,
                             rpms_pkg::ST_TX};
  endfunction

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xtal_enable <= 1'b0;
      pll_enable  <= 1'b0;
    end
    else
    begin
      xtal_enable <= state_next != rpms_pkg::ST_SLEEP;
      pll_enable  <= state_next == rpms_pkg::ST_PLL_START ||
                     state_locked(state_next);
    end
  end

  // ----------------------------------------------------------------
  // radio paths, open only in their own locked states
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
    end
    else
    begin
      rx_enable <= state_next == rpms_pkg::ST_RX;
      tx_enable <= state_next == rpms_pkg::ST_TX;
    end
  end

  // ----------------------------------------------------------------
  // buffered clock output and lock pin
  // ----------------------------------------------------------------
  // clock output waits for the crystal to settle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      clk_out_enable <= 1'b0;
    else
      clk_out_enable <= !(state_next inside {rpms_pkg::ST_SLEEP,
                          rpms_pkg::ST_XTAL_START});
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pll_lock <= 1'b0;
    else
      pll_lock <= state_locked(state_next);
  end

  // ----------------------------------------------------------------
  // mode reached, as reported to the host
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      op_mode <= rpms_pkg::MODE_SLEEP;
    else
    begin
      case (state_next)
        rpms_pkg::ST_SLEEP:      op_mode <= rpms_pkg::MODE_SLEEP;
        rpms_pkg::ST_XTAL_START: op_mode <= rpms_pkg::MODE_SLEEP;
        rpms_pkg::ST_STANDBY:    op_mode <= rpms_pkg::MODE_STANDBY;
        rpms_pkg::ST_PLL_START:  op_mode <= rpms_pkg::MODE_STANDBY;
        rpms_pkg::ST_SYNTH:      op_mode <= rpms_pkg::MODE_SYNTH;
        rpms_pkg::ST_RX:         op_mode <= rpms_pkg::MODE_RX;
        rpms_pkg::ST_TX:         op_mode <= rpms_pkg::MODE_TX;
        default:                 op_mode <= rpms_pkg::MODE_SLEEP;
      endcase
    end
  end

endmodule

/* verif/rpms_seq_properties.sv */
// concurrent checks on the mode sequencer ports
// assumes bind onto rpms_sequencer, parameters handed on
`timescale 1ns/1ps
module rpms_seq_properties
#(
  parameter int XTAL_START_CYC = rpms_pkg::XTAL_START_CYC,
  parameter int PLL_LOCK_CYC   = rpms_pkg::PLL_LOCK_CYC
)
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       config_port_select_n,
  input wire logic       spi_sck,
  input wire logic       spi_sdi,
  input wire logic       spi_sdo,
  input wire logic       spi_sdo_oe,
  input wire logic       xtal_enable,
  input wire logic       pll_enable,
  input wire logic       rx_enable,
  input wire logic       tx_enable,
  input wire logic       clk_out_enable,
  input wire logic       pll_lock,
  input wire logic [2:0] op_mode
);
  // ----------------------------------------------------------------
  // oscillator wait counters
  // ----------------------------------------------------------------
  int xtal_cnt;
  int pll_cnt;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      xtal_cnt <= 0;
      pll_cnt  <= 0;
    end
    else
    begin
      xtal_cnt <= (xtal_enable && !clk_out_enable) ? xtal_cnt + 1 : 0;
      pll_cnt  <= (pll_enable && !pll_lock) ? pll_cnt + 1 : 0;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sleep_clk_off_a:
    assert property (op_mode == rpms_pkg::MODE_SLEEP |-> !clk_out_enable)
    else $error("clock output on while asleep");
  xtal_start_time_a:
    assert property (xtal_cnt <= XTAL_START_CYC + 2)
    else $error("crystal start too long");
  pll_lock_time_a:
    assert property (pll_cnt <= PLL_LOCK_CYC + 2)
    else $error("pll lock too long");
  lock_pin_state_a:
    assert property (pll_lock |-> pll_enable && xtal_enable)
    else $error("lock shown without pll");
  rf_after_lock_a:
    assert property ((rx_enable || tx_enable) |-> pll_lock)
    else $error("radio path on without lock");
  rf_mode_decode_a:
    assert property (op_mode == rpms_pkg::MODE_TX |-> tx_enable && !rx_enable)
    else $error("transmit path does not match mode");
  rx_mode_decode_a:
    assert property (op_mode == rpms_pkg::MODE_RX |-> rx_enable && !tx_enable)
    else $error("receive path does not match mode");
  sdo_idle_a:
    assert property ($past(config_port_select_n, 2) |-> !spi_sdo_oe)
    else $error("data out driven while deselected");
  standby_decode_a:
    assert property (op_mode == rpms_pkg::MODE_STANDBY
      |-> xtal_enable && clk_out_enable && !pll_lock && !rx_enable)
    else $error("standby enables wrong");
  sleep_drop_a:
    assert property ($fell(xtal_enable) |-> !pll_enable && !rx_enable
      && !tx_enable && !clk_out_enable && !pll_lock)
    else $error("sleep entry left enables on");
  write_then_start_a:
    assert property ($rose(xtal_enable) |-> $past(config_port_select_n, 1)
      && $past(config_port_select_n, 4))
    else $error("crystal started before write ended");
  cover property ($rose(tx_enable));
  cover property ($rose(rx_enable));
  cover property ($fell(xtal_enable));
  cover property ($rose(spi_sdo_oe));
endmodule

bind rpms_sequencer rpms_seq_properties
#(.XTAL_START_CYC(XTAL_START_CYC), .PLL_LOCK_CYC(PLL_LOCK_CYC)) chk
(.clk(clk), .sys_rst(sys_rst), .config_port_select_n(config_port_select_n),
 .spi_sck(spi_sck), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
 .spi_sdo_oe(spi_sdo_oe), .xtal_enable(xtal_enable),
 .pll_enable(pll_enable), .rx_enable(rx_enable), .tx_enable(tx_enable),
 .clk_out_enable(clk_out_enable), .pll_lock(pll_lock), .op_mode(op_mode));

/* verif/rpms_host_model.sv */
// host model on the spi configuration port
// assumes its own clock, never the buffered clock output
`timescale 1ns/1ps
module rpms_host_model
(
  input  wire logic clk,
  input  wire logic spi_sdo,
  output logic      sel_n,
  output logic      sck,
  output logic      sdi,
  output logic      fifo_port_select_n
);
  // parked as for sleep at start
  initial
  begin
    sel_n = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
    fifo_port_select_n = 1'b1;
  end
  // one 16 bit frame, sck 16 clk per bit, stands still outside frames
  task automatic frame(input logic [15:0] f, output logic [7:0] r);
    r = 8'h00;
    sel_n <= 1'b1;
    repeat (6) @(posedge clk);
    sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      sdi <= f[i];
      repeat (8) @(posedge clk);
      sck <= 1'b1;
      if (i < 8)
        r[i] = spi_sdo;
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    sel_n <= 1'b1;
    sdi   <= ~f[0];
    repeat (6) @(posedge clk);
    // sdo left undriven; pins parked after a sleep write
    if (f[15:5] == 11'h000)
    begin
      sel_n <= 1'b0;
      sdi   <= 1'b0;
    end
  endtask
endmodule

/* verif/rpms_sequencer_tb.sv */
// self-checking bench for the mode sequencer
// assumes host model and bound checker compiled alongside
`timescale 1ns/1ps
module rpms_sequencer_tb;
  localparam int XC = 50;
  localparam int PC = 20;
  localparam logic [2:0] ROW_MODE [7] = '{3'h1, 3'h2, 3'h3, 3'h2, 3'h4,
                                         3'h1, 3'h0};
  localparam logic [8:0] ROW_EXP [7] = '{9'h111, 9'h19A, 9'h1DB, 9'h19A,
                                        9'h1BC, 9'h111, 9'h000};
  logic       clk;
  logic       sys_rst;
  logic       sel_n, sck, sdi, sdo, sdo_oe;
  logic       xtal, pll, rx, tx, clko, lock;
  logic [2:0] mode;
  logic [7:0] rd;
  logic [8:0] outs;
  int         n_fail, samples_checked, cyc;
  assign outs = {xtal, pll, rx, tx, clko, lock, mode};
  rpms_host_model host (.clk(clk), .spi_sdo(sdo), .sel_n(sel_n), .sck(sck),
    .sdi(sdi), .fifo_port_select_n());
  rpms_sequencer #(.XTAL_START_CYC(XC), .PLL_LOCK_CYC(PC)) dut (.clk(clk),
    .sys_rst(sys_rst), .config_port_select_n(sel_n), .spi_sck(sck),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .xtal_enable(xtal),
    .pll_enable(pll), .rx_enable(rx), .tx_enable(tx),
    .clk_out_enable(clko), .pll_lock(lock), .op_mode(mode));
  initial
    clk = 1'b0;
  always #2.5 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_out(input logic [8:0] e);
    cyc = 0;
    while (outs !== e && cyc < 300)
    begin
      @(posedge clk);
      cyc++;
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    test_done();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    chk(outs, 9'h000);
    chk({8'h00, sdo_oe}, 9'h000);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 7; k++)
    begin
      // a bit time before each change, also after transmit
      repeat (16) @(posedge clk);
      host.frame({8'h00, ROW_MODE[k], 5'h00}, rd);
      wait_out(ROW_EXP[k]);
      chk(outs, ROW_EXP[k]);
    end
    // reserved code ignored; let the sleep parking settle first
    repeat (16) @(posedge clk);
    host.frame(16'h00A0, rd);
    repeat (100) @(posedge clk);
    chk(outs, 9'h000);
    // sleep straight to transmit, sequenced through lock
    host.frame(16'h0080, rd);
    wait_out(9'h1BC);
    chk(outs, 9'h1BC);
    chk({8'h00, cyc <= XC + PC + 10}, 9'h001);
    host.frame(16'h8000, rd);
    chk({1'b0, rd}, 9'h080);
    host.frame(16'h0000, rd);
    repeat (2) @(posedge clk);
    chk(outs, 9'h000);
    // reset during crystal start
    host.frame(16'h0020, rd);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(outs, 9'h000);
    sys_rst <= 1'b0;
    repeat (XC + 20) @(posedge clk);
    chk(outs, 9'h000);
    test_done();
  end
endmodule
